// ==== src/nvm_ctrl_pkg.sv ====
// Constants shared by the byte-wide data EEPROM access controller and its array.
// Assumes one CPU-side clock and a tick pulse from the calibrated RC oscillator.
package nvm_ctrl_pkg;
	// ==========================================================
	// Geometry
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	// ==========================================================
	// Register selection indices on the CPU register port
	localparam logic [1:0] REG_ADDR_LOW = 2'h0;
	localparam logic [1:0] REG_ADDR_HIGH = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	localparam logic [1:0] REG_CTRL = 2'h3;

	// ==========================================================
	// Control register field positions
	localparam int CTRL_MODE_HI = 5;
	localparam int CTRL_MODE_LO = 4;
	localparam int CTRL_IRQ_EN = 3;
	localparam int CTRL_ARM = 2;
	localparam int CTRL_PROG = 1;
	localparam int CTRL_READ = 0;
	localparam int HIGH_ADDR_BIT = 0;

	// ==========================================================
	// Programming modes
	localparam logic [1:0] MODE_ATOMIC = 2'h0;
	localparam logic [1:0] MODE_ERASE = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_RESERVED = 2'h3;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ==========================================================
	// Reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [8:0] ADDR_RESET = 9'h000;

	// ==========================================================
	// Timing: CPU cycles and programming times on the RC oscillator
	localparam logic [2:0] ARM_HOLD_CYCLES = 3'h4;
	localparam logic [2:0] READ_HALT_CYCLES = 3'h4;
	localparam logic [2:0] PROG_HALT_CYCLES = 3'h2;
	localparam int RC_FREQ_KHZ = 8000;
	localparam int ATOMIC_TIME_US = 3400;
	localparam int SPLIT_TIME_US = 1800;
	localparam logic [15:0] ATOMIC_TICKS_DEF = 16'((ATOMIC_TIME_US * RC_FREQ_KHZ + 999) / 1000);
	localparam logic [15:0] SPLIT_TICKS_DEF = 16'((SPLIT_TIME_US * RC_FREQ_KHZ + 999) / 1000);
endpackage

// ==== src/nvm_port_if.sv ====
// Carrier between the access controller and the EEPROM array.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface nvm_port_if
	import nvm_ctrl_pkg::*;
();
	logic we;
	logic re;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	// ==========================================================
	// Views
	modport ctrl (output we, output re, output addr, output wdata, input rdata);
	modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

// ==== src/nvm_array.sv ====
// Byte-wide EEPROM storage with a registered read port.
// Assumes the controller pulses we or re for one cycle per access.
`timescale 1ns/10ps
module nvm_array
	import nvm_ctrl_pkg::*;
#(
	parameter int DEPTH = 512
)
(
	// Clock
	input wire logic mclk,
	// Controller side
	nvm_port_if.mem port
);
	logic [DATA_W-1:0] cells [DEPTH];
	logic [DATA_W-1:0] rdata_ff;

	// ==========================================================
	// Storage and registered read
	always_ff @(posedge mclk)
	begin
		if (port.we)
		begin
			cells[port.addr] <= port.wdata;
		end
		if (port.re)
		begin
			rdata_ff <= cells[port.addr];
		end
	end

	// Read data straight from its register
	assign port.rdata = rdata_ff;
endmodule // nvm_array

// ==== src/eeprom_access_controller.sv ====
// CPU register front end for the on-chip data EEPROM: address, data and control registers.
// Assumes synchronous CPU register strobes and a one-cycle rc_tick from the calibrated RC oscillator.
// Operation
// - Erase and write durations are counted in ticks of the calibrated RC oscillator, never CPU cycles.
// - Software loads the address and sets the read strobe, and the byte then appears in the data register.
// - A reset during programming lets the running operation finish; reset still clears the data register that modes 00 and 10 write.
// - The 9-bit byte address is the low register plus bit 0 of the high register as bit 8.
// - High address bits 7 to 1 read as zero and cannot be written.
// - The address resets to zero unless programming is running, when it is kept, and software must load it first.
// - The data register holds the byte to program, takes the byte read, and resets to zero.
// - Control holds mode in 5:4, ready enable in 3, arm in 2, program strobe in 1, read strobe in 0.
// - Control bits 7 and 6 read as zero and software writes them as zero.
// - Mode 00 is erase plus write, 01 erase only, 10 write only, 11 reserved, with their times.
// - The arm bit clears four cycles after it is set, and a program strobe without it does nothing.
// - The program strobe clears when the time elapses, and mode writes are ignored while it is set.
// - A read halts the CPU four cycles, and during programming reads and address changes are refused.
`timescale 1ns/10ps
module eeprom_access_controller
	import nvm_ctrl_pkg::*;
#(
	parameter logic [15:0] ATOMIC_TICKS = ATOMIC_TICKS_DEF,
	parameter logic [15:0] SPLIT_TICKS = SPLIT_TICKS_DEF,
	parameter int DEPTH = 512
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Calibrated oscillator tick
	input wire logic rc_tick,
	// CPU register port
	input wire logic [1:0] reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// CPU status
	output logic cpu_halt,
	output logic ready_irq
);
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [1:0] mode;
		logic irq_en;
		logic arm;
		logic [2:0] arm_cnt;
		logic busy;
		logic [1:0] op_mode;
		logic [15:0] prog_cnt;
		logic [2:0] halt_cnt;
		logic halt;
		logic mem_we;
		logic mem_re;
		logic rd_pend;
		logic [7:0] rdata;
		logic irq;
	} state_type;

	state_type st_ff;
	state_type nxt_st;
	logic rd_go;
	logic prog_go;
	logic arm_wr;
	nvm_port_if port ();

	// ==========================================================
	// Helpers
	// Programming length in oscillator ticks for a mode
	function automatic logic [15:0] prog_ticks(input logic [1:0] mode);
		prog_ticks = (mode == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
	endfunction

	// Control register image with reserved bits zero
	function automatic logic [7:0] ctrl_image(input state_type s);
		ctrl_image = 8'h00;
		ctrl_image[CTRL_MODE_HI:CTRL_MODE_LO] = s.mode;
		ctrl_image[CTRL_IRQ_EN] = s.irq_en;
		ctrl_image[CTRL_ARM] = s.arm;
		ctrl_image[CTRL_PROG] = s.busy;
	endfunction

	// Strobe decode from the current control write
	assign arm_wr = reg_wr && (reg_sel == REG_CTRL) && reg_wdata[CTRL_ARM];
	assign rd_go = reg_wr && (reg_sel == REG_CTRL) && reg_wdata[CTRL_READ] && !st_ff.busy;
	assign prog_go = reg_wr && (reg_sel == REG_CTRL) && reg_wdata[CTRL_PROG] && st_ff.arm && !st_ff.busy
		&& (st_ff.mode != MODE_RESERVED);

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.mem_we = 1'b0;
		nxt_st.mem_re = 1'b0;
		nxt_st.rd_pend = st_ff.mem_re;
		// CPU halt countdown
		if (st_ff.halt_cnt != 3'h0)
		begin
			nxt_st.halt_cnt = st_ff.halt_cnt - 3'h1;
		end
		// Arm window closes by itself
		if (st_ff.arm)
		begin
			if (st_ff.arm_cnt == 3'h0)
			begin
				nxt_st.arm = 1'b0;
			end
			else
			begin
				nxt_st.arm_cnt = st_ff.arm_cnt - 3'h1;
			end
		end
		// Programming timer on the oscillator tick
		if (st_ff.busy && rc_tick)
		begin
			if (st_ff.prog_cnt == 16'h0000)
			begin
				nxt_st.busy = 1'b0;
				nxt_st.mem_we = 1'b1;
			end
			else
			begin
				nxt_st.prog_cnt = st_ff.prog_cnt - 16'h0001;
			end
		end
		// Read result lands in the data register
		if (st_ff.rd_pend)
		begin
			nxt_st.data = port.rdata;
		end
		// Register writes
		if (reg_wr)
		begin
			if (reg_sel == REG_ADDR_LOW)
			begin
				if (!st_ff.busy)
				begin
					nxt_st.addr[7:0] = reg_wdata;
				end
			end
			else if (reg_sel == REG_ADDR_HIGH)
			begin
				if (!st_ff.busy)
				begin
					nxt_st.addr[8] = reg_wdata[HIGH_ADDR_BIT];
				end
			end
			else if (reg_sel == REG_DATA)
			begin
				nxt_st.data = reg_wdata;
			end
			else
			begin
				nxt_st.irq_en = reg_wdata[CTRL_IRQ_EN];
				if (!st_ff.busy)
				begin
					nxt_st.mode = reg_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
				end
				if (arm_wr)
				begin
					nxt_st.arm = 1'b1;
					nxt_st.arm_cnt = ARM_HOLD_CYCLES - 3'h1;
				end
				if (prog_go)
				begin
					nxt_st.busy = 1'b1;
					nxt_st.op_mode = st_ff.mode;
					nxt_st.prog_cnt = prog_ticks(st_ff.mode) - 16'h0001;
					nxt_st.halt_cnt = PROG_HALT_CYCLES;
				end
				if (rd_go)
				begin
					nxt_st.mem_re = 1'b1;
					nxt_st.halt_cnt = READ_HALT_CYCLES;
				end
			end
		end
		// Register reads
		if (reg_rd)
		begin
			if (reg_sel == REG_ADDR_LOW)
			begin
				nxt_st.rdata = st_ff.addr[7:0];
			end
			else if (reg_sel == REG_ADDR_HIGH)
			begin
				nxt_st.rdata = {7'h00, st_ff.addr[8]};
			end
			else if (reg_sel == REG_DATA)
			begin
				nxt_st.rdata = st_ff.data;
			end
			else
			begin
				nxt_st.rdata = ctrl_image(st_ff);
			end
		end
		// Reset keeps the timer, mode and address of a running programming operation and clears its data byte
		if (!rst_n)
		begin
			nxt_st.data = DATA_RESET;
			nxt_st.irq_en = 1'b0;
			nxt_st.arm = 1'b0;
			nxt_st.arm_cnt = 3'h0;
			nxt_st.halt_cnt = 3'h0;
			nxt_st.mem_re = 1'b0;
			nxt_st.rd_pend = 1'b0;
			nxt_st.rdata = 8'h00;
			// Clearing branch also takes an unknown busy at power-up
			if (st_ff.busy)
			begin
				nxt_st.mode = st_ff.mode;
			end
			else
			begin
				nxt_st.mode = MODE_RESET;
				nxt_st.busy = 1'b0;
				nxt_st.op_mode = MODE_RESET;
				nxt_st.prog_cnt = 16'h0000;
				nxt_st.addr = ADDR_RESET;
				nxt_st.mem_we = 1'b0;
			end
		end
		nxt_st.halt = (nxt_st.halt_cnt != 3'h0);
		nxt_st.irq = nxt_st.irq_en && !nxt_st.busy;
	end

	// State register
	always_ff @(posedge mclk)
	begin
		st_ff <= nxt_st;
	end

	// ==========================================================
	// Array connection and outputs
	assign port.we = st_ff.mem_we;
	assign port.re = st_ff.mem_re;
	assign port.addr = st_ff.addr;
	assign port.wdata = (st_ff.op_mode == MODE_ERASE) ? ERASED_BYTE : st_ff.data;
	assign reg_rdata = st_ff.rdata;
	assign cpu_halt = st_ff.halt;
	assign ready_irq = st_ff.irq;

	nvm_array #(.DEPTH(DEPTH)) u_array (
		.mclk(mclk),
		.port(port)
	);

	// ==========================================================
	// Checks
	a_arm_self_clear: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$rose(st_ff.arm) ##1 (!arm_wr)[*3] |-> ##1 !st_ff.arm)
		else $error("arm bit did not clear after four cycles");
	a_strobe_needs_arm: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$rose(st_ff.busy) |-> $past(st_ff.arm))
		else $error("programming started without arm");
	a_reserved_no_op: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$rose(st_ff.busy) |-> st_ff.op_mode != MODE_RESERVED)
		else $error("reserved mode started programming");
	a_mode_locked: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$past(st_ff.busy) |-> $stable(st_ff.mode) && $stable(st_ff.addr))
		else $error("mode or address changed while programming");
	a_read_halt_four: assert property (
		@(posedge mclk) disable iff (!rst_n)
		rd_go |=> cpu_halt[*4] ##1 !cpu_halt)
		else $error("read halt not four cycles");
	a_read_data_load: assert property (
		@(posedge mclk) disable iff (!rst_n)
		rd_go |-> ##3 (st_ff.data == $past(port.rdata)))
		else $error("read byte not loaded into data register");
	a_prog_end_tick: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$fell(st_ff.busy) |-> $past(rc_tick) && ($past(st_ff.prog_cnt) == 16'h0000) && port.we)
		else $error("programming ended off the oscillator count");
	a_reset_keeps_busy: assert property (
		@(posedge mclk)
		(!rst_n && st_ff.busy && !rc_tick) |=> st_ff.busy)
		else $error("reset aborted programming");
	a_ready_request: assert property (
		@(posedge mclk) disable iff (!rst_n)
		$fell(st_ff.busy) && st_ff.irq_en |-> ready_irq)
		else $error("ready request missing after programming");
	a_high_reserved: assert property (
		@(posedge mclk) disable iff (!rst_n)
		reg_rd && (reg_sel == REG_ADDR_HIGH) |=> reg_rdata[7:1] == 7'h00)
		else $error("high address reserved bits not zero");
endmodule // eeprom_access_controller

// ==== bench/tb_eeprom_access_controller.sv ====
// Self-checking bench for the data EEPROM access controller, with a byte model of the array.
// Assumes a 50 MHz mclk; the RC oscillator tick is made here, one pulse every fourth cycle.
`timescale 1ns/10ps
module tb_eeprom_access_controller
	import nvm_ctrl_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic rc_tick = 1'b0;
	logic rc_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] reg_sel = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] v;
	logic cpu_halt;
	logic ready_irq;
	logic [8:0] a;
	int num_errors = 0;
	int samples_checked = 0;
	int tcnt = 0;
	int ticks = 0;
	localparam logic [15:0] ATOMIC_N = 16'h0005;
	localparam logic [15:0] SPLIT_N = 16'h0003;
	int i;
	int model_mem [int];

	// ==========================================================
	// Clock, oscillator tick and design
	always #10 mclk = ~mclk;
	// Tick pulse every fourth cycle while the oscillator runs; ticks counts those the design samples
	always @(posedge mclk)
	begin
		tcnt <= tcnt + 1;
		if (rc_tick)
			ticks <= ticks + 1;
		rc_tick <= #1 rc_en && (tcnt % 4 == 0);
	end
	eeprom_access_controller #(.ATOMIC_TICKS(ATOMIC_N), .SPLIT_TICKS(SPLIT_N), .DEPTH(512)) i_dut (.mclk(mclk),
		.rst_n(rst_n), .rc_tick(rc_tick), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt), .ready_irq(ready_irq));

	// ==========================================================
	// Register port tasks and comparison
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [1:0] s, input logic [7:0] x);
		cyc(1);
		reg_sel = s;
		reg_wdata = x;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] x);
		cyc(1);
		reg_sel = s;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		x = reg_rdata;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Poll the program strobe until it clears, bounded
	task automatic wait_idle();
		int n = 0;
		v = 8'hFF;
		while (v[CTRL_PROG] !== 1'b0 && n < 300)
		begin
			rd(REG_CTRL, v);
			n++;
		end
		chk("busy", {7'h00, v[CTRL_PROG]}, 8'h00);
	endtask
	// Full programming sequence; the model follows the mode
	task automatic prog(input logic [8:0] pa, input logic [7:0] pd, input logic [1:0] m);
		wait_idle();
		wr(REG_CTRL, {2'h0, m, 4'h8});
		wr(REG_ADDR_HIGH, {7'($urandom), pa[8]});
		wr(REG_ADDR_LOW, pa[7:0]);
		rd(REG_ADDR_HIGH, v);
		chk("addr high", v, {7'h00, pa[8]});
		wr(REG_DATA, pd);
		wr(REG_CTRL, {2'h0, m, 4'hC});
		wr(REG_CTRL, {2'h0, m, 4'hE});
		if (m == MODE_ERASE)
			model_mem[pa] = 8'hFF;
		else if (m != MODE_RESERVED)
			model_mem[pa] = pd;
	endtask
	// Programming length in oscillator ticks, seen through the ready request
	task automatic prog_time(input logic [1:0] m);
		int t0 = ticks;
		int n = 0;
		logic [7:0] e = (m == MODE_RESERVED) ? 8'h00 : (m == MODE_ATOMIC) ? 8'(ATOMIC_N) : 8'(SPLIT_N);
		while (ready_irq !== 1'b1 && n < 400)
		begin
			cyc(1);
			n++;
		end
		chk("prog ticks", 8'(ticks - t0), e);
	endtask
	// Read strobe, halt count and returned byte
	task automatic readbyte(input logic [8:0] ra);
		int h = 0;
		wait_idle();
		wr(REG_ADDR_HIGH, {7'h00, ra[8]});
		wr(REG_ADDR_LOW, ra[7:0]);
		wr(REG_CTRL, 8'h01);
		repeat (8)
		begin
			if (cpu_halt === 1'b1)
				h++;
			cyc(1);
		end
		chk("halt cycles", 8'(h), 8'h04);
		rd(REG_DATA, v);
		chk("read byte", v, 8'(model_mem[ra]));
	endtask

	// ==========================================================
	// Test sequence
	initial
	begin
		void'($urandom(32'hB385));
		cyc(10);
		rst_n = 1'b1;
		rd(REG_DATA, v);
		chk("data reset", v, 8'h00);
		rd(REG_CTRL, v);
		chk("ctrl reset", v, 8'h00);
		wr(REG_CTRL, 8'hFC);
		rd(REG_CTRL, v);
		chk("ctrl fields", v, 8'h3C);
		chk("ready idle", {7'h00, ready_irq}, 8'h01);
		cyc(6);
		rd(REG_CTRL, v);
		chk("arm timeout", v, 8'h38);
		wr(REG_CTRL, 8'h02);
		rd(REG_CTRL, v);
		chk("unarmed strobe", v, 8'h00);
		// Every mode, with the low address byte at both its edges and bit 8 set
		for (i = 0; i < 8; i++)
		begin
			a = (i == 0) ? 9'h1FF : (i == 1) ? 9'h100 : 9'($urandom);
			prog(a, 8'($urandom), MODE_ATOMIC);
			prog_time(MODE_ATOMIC);
			readbyte(a);
			prog(a, 8'($urandom), 2'(i));
			prog_time(2'(i));
			readbyte(a);
		end
		// Busy with the oscillator stopped; refusals meanwhile
		prog(9'h0AA, 8'h5A, MODE_ATOMIC);
		rc_en = 1'b0;
		cyc(50);
		rd(REG_CTRL, v);
		chk("busy held", v, 8'h0A);
		wr(REG_ADDR_LOW, 8'h55);
		wr(REG_CTRL, 8'h39);
		chk("read refused", {7'h00, cpu_halt}, 8'h00);
		rd(REG_CTRL, v);
		chk("mode locked", v, 8'h0A);
		chk("ready busy", {7'h00, ready_irq}, 8'h00);
		rc_en = 1'b1;
		wait_idle();
		chk("ready again", {7'h00, ready_irq}, 8'h01);
		wr(REG_DATA, 8'h00);
		wr(REG_CTRL, 8'h01);
		cyc(4);
		rd(REG_DATA, v);
		chk("address kept", v, 8'h5A);
		// Reset in mid-programming; the data register was cleared
		prog(9'h033, 8'hC3, MODE_ATOMIC);
		cyc(3);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		rd(REG_DATA, v);
		chk("data after reset", v, 8'h00);
		model_mem[9'h033] = 0;
		readbyte(9'h033);
		report_and_stop();
	end

	// Watchdog against a hang
	initial
	begin
		cyc(20000);
		num_errors++;
		report_and_stop();
	end
endmodule // tb_eeprom_access_controller
